// [clock_speed_and_usb_pll_control.sv]
// Contract
// - double speed bit: 6 else 12 periods
// - serial speed bit picks 6/12 when double
// - timer two speed bit picks 6/12
// - timer one speed bit picks 6/12
// - timer zero speed bit picks 6/12
// - spi speed bit picks 6/12
// - reserved bits read as zero
// - external clock select bypasses loop, oscillator off
// - otherwise loop clock used, oscillator on
// - loop enable starts and stops loop
// - lock flag follows hardware lock only
// - divider packs feedback high, reference low
// - all special function registers reset to zero, oscillator enable resets to one
// - twi, watchdog, counter array pick 6/12
`include "clock_speed_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module clock_speed_and_usb_pll_control (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    // analog loop interface
    input wire logic loop_lock_in,
    output logic loop_enable_out,
    output logic [3:0] feedback_divider_out,
    output logic [3:0] reference_divider_out,
    // usb clock source steering
    output logic external_usb_clock_select_out,
    output logic osc_enable_out,
    // machine and peripheral cycle strobes
    output logic cpu_cycle_en_out,
    output logic [7:0] periph_cycle_en_out
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] speed_a_r; // clock speed control a
    logic [7:0] speed_b_r; // clock speed control b
    logic [2:1] loop_ctrl_r; // external select and loop enable
    logic [7:0] loop_div_r; // feedback and reference dividers
    logic lock_meta_r; // lock synchroniser first stage
    logic lock_sync_r; // lock synchroniser second stage
    logic [3:0] cpu_cnt_r; // machine cycle period counter
    logic [3:0] per_cnt_r [8]; // peripheral period counters
    logic [7:0] per_slow_r; // per-peripheral twelve-period choice
    logic [7:0] per_en_r; // peripheral cycle strobes
    logic cpu_en_r; // machine cycle strobe
    logic [7:0] rdata_r; // read data
    logic osc_en_r; // crystal oscillator enable, off while the external clock is used
    logic dbl; // double speed active
    logic [7:0] slow_sel; // raw per-peripheral speed bits
    assign dbl = speed_a_r[`CLK_BIT_DOUBLE];
    always_comb begin
        slow_sel = 8'h00;
        slow_sel[clock_speed_pkg::PER_SERIAL] = speed_a_r[`CLK_BIT_SERIAL];
        slow_sel[clock_speed_pkg::PER_T0] = speed_a_r[`CLK_BIT_T0];
        slow_sel[clock_speed_pkg::PER_T1] = speed_a_r[`CLK_BIT_T1];
        slow_sel[clock_speed_pkg::PER_T2] = speed_a_r[`CLK_BIT_T2];
        slow_sel[clock_speed_pkg::PER_SPI] = speed_b_r[`CLK_BIT_SPI];
        slow_sel[clock_speed_pkg::PER_TWI] = speed_a_r[`CLK_BIT_TWI];
        slow_sel[clock_speed_pkg::PER_WDOG] = speed_a_r[`CLK_BIT_WDOG];
        slow_sel[clock_speed_pkg::PER_CARRAY] = speed_a_r[`CLK_BIT_CARRAY];
    end
    // ************************************************************
    // register writes
    // ************************************************************
    // software writes; reserved bits are masked off, never stored
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            speed_a_r <= `CLK_RESET_VALUE;
            speed_b_r <= `CLK_RESET_VALUE;
            loop_ctrl_r <= 2'b00;
            loop_div_r <= `CLK_RESET_VALUE;
            osc_en_r <= 1'b1;
        end else if (sfr_wr_in) begin
            case (sfr_addr_in)
                `CLK_SFR_SPEED_A: speed_a_r <= sfr_wdata_in;
                `CLK_SFR_SPEED_B: speed_b_r <= sfr_wdata_in & `CLK_MASK_SPEED_B;
                `CLK_SFR_LOOP_CTRL: begin
                    loop_ctrl_r <= sfr_wdata_in[2:1];
                    // oscillator follows the source choice in the same edge
                    osc_en_r <= ~sfr_wdata_in[`CLK_BIT_EXT_USB];
                end
                `CLK_SFR_LOOP_DIV: loop_div_r <= sfr_wdata_in;
                default: begin
                end
            endcase
        end
    end
    // ************************************************************
    // lock synchroniser
    // ************************************************************
    // lock comes from the analog loop, outside this clock domain
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            lock_meta_r <= 1'b0;
            lock_sync_r <= 1'b0;
        end else begin
            lock_meta_r <= loop_lock_in;
            lock_sync_r <= lock_meta_r;
        end
    end
    // ************************************************************
    // read port
    // ************************************************************
    // registered read; unknown addresses and reserved bits give zero
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                `CLK_SFR_SPEED_A: rdata_r <= speed_a_r;
                `CLK_SFR_SPEED_B: rdata_r <= speed_b_r;
                `CLK_SFR_LOOP_CTRL: rdata_r <= {5'b00000, loop_ctrl_r, lock_sync_r};
                `CLK_SFR_LOOP_DIV: rdata_r <= loop_div_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    // ************************************************************
    // machine cycle timing
    // ************************************************************
    // counter reloads at the end of each cycle with the current mode
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cpu_cnt_r <= `CLK_PER_SLOW_M1;
            cpu_en_r <= 1'b0;
        end else if (cpu_cnt_r == 4'h0) begin
            cpu_cnt_r <= dbl ? `CLK_PER_DBL_M1 : `CLK_PER_SLOW_M1;
            cpu_en_r <= 1'b1;
        end else begin
            cpu_cnt_r <= cpu_cnt_r - 4'h1;
            cpu_en_r <= 1'b0;
        end
    end
    // ************************************************************
    // peripheral cycle timing
    // ************************************************************
    // the speed choice is sampled only at a cycle boundary so a
    // change never shortens a cycle in progress
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 8; i++) begin
                per_cnt_r[i] <= `CLK_PER_SLOW_M1;
            end
            per_slow_r <= 8'hff;
            per_en_r <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (per_cnt_r[i] == 4'h0) begin
                    per_slow_r[i] <= ~dbl | slow_sel[i];
                    per_cnt_r[i] <= (~dbl | slow_sel[i]) ? `CLK_PER_SLOW_M1
                                                         : `CLK_PER_DBL_M1;
                    per_en_r[i] <= 1'b1;
                end else begin
                    per_cnt_r[i] <= per_cnt_r[i] - 4'h1;
                    per_en_r[i] <= 1'b0;
                end
            end
        end
    end
    // ************************************************************
    // outputs
    // ************************************************************
    assign sfr_rdata_out = rdata_r;
    assign loop_enable_out = loop_ctrl_r[`CLK_BIT_LOOP_EN];
    assign external_usb_clock_select_out = loop_ctrl_r[`CLK_BIT_EXT_USB];
    assign osc_enable_out = osc_en_r;
    assign feedback_divider_out = loop_div_r[7:4];
    assign reference_divider_out = loop_div_r[3:0];
    assign cpu_cycle_en_out = cpu_en_r;
    assign periph_cycle_en_out = per_en_r;
    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_boundary;
        cpu_cnt_r == 4'h0;
    endsequence
    a_cpu_dbl_len: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (s_boundary and dbl) |=> (cpu_cnt_r == `CLK_PER_DBL_M1))
        else $error("double speed reload wrong");
    a_cpu_twelve_len: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (s_boundary and !dbl) |=> (cpu_cnt_r == `CLK_PER_SLOW_M1))
        else $error("standard reload wrong");
    a_slow_ignores_bits: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (!dbl && per_cnt_r[0] == 4'h0) |=> per_slow_r[0])
        else $error("peripheral fast in standard mode");
    a_spi_fast: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (dbl && !speed_b_r[0] && per_cnt_r[4] == 4'h0) |=> (per_cnt_r[4] == `CLK_PER_DBL_M1))
        else $error("spi not fast");
    a_strobe_single: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        per_en_r[1] |=> !per_en_r[1])
        else $error("timer strobe too long");
    a_reserved_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (sfr_rd_in && sfr_addr_in == `CLK_SFR_LOOP_CTRL) |=> (sfr_rdata_out[7:3] == 5'h00))
        else $error("reserved bits nonzero");
    a_lock_follows: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (loop_lock_in [*2]) |=> lock_sync_r)
        else $error("lock flag not following");
    a_osc_ext: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        external_usb_clock_select_out |-> !osc_enable_out)
        else $error("oscillator on with external clock");
    a_osc_loop: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !external_usb_clock_select_out |-> osc_enable_out)
        else $error("oscillator off with loop clock");
    a_loop_enable: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (sfr_wr_in && sfr_addr_in == `CLK_SFR_LOOP_CTRL) |=>
        (loop_enable_out == $past(sfr_wdata_in[`CLK_BIT_LOOP_EN])))
        else $error("loop enable not stored");
    a_div_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (sfr_wr_in && sfr_addr_in == `CLK_SFR_LOOP_DIV) |=>
        (feedback_divider_out == $past(sfr_wdata_in[7:4])))
        else $error("divider not stored");
endmodule
`default_nettype wire

// [clock_speed_defs.svh]
`ifndef CLOCK_SPEED_DEFS_SVH
`define CLOCK_SPEED_DEFS_SVH
// ************************************************************
// special function register addresses
// ************************************************************
`define CLK_SFR_SPEED_A 8'h8f
`define CLK_SFR_LOOP_CTRL 8'ha3
`define CLK_SFR_LOOP_DIV 8'ha4
`define CLK_SFR_SPEED_B 8'haf
// ************************************************************
// field positions
// ************************************************************
`define CLK_BIT_DOUBLE 0
`define CLK_BIT_T0 1
`define CLK_BIT_T1 2
`define CLK_BIT_T2 3
`define CLK_BIT_SERIAL 4
`define CLK_BIT_CARRAY 5
`define CLK_BIT_WDOG 6
`define CLK_BIT_TWI 7
`define CLK_BIT_SPI 0
`define CLK_BIT_LOCK 0
`define CLK_BIT_LOOP_EN 1
`define CLK_BIT_EXT_USB 2
// ************************************************************
// reset values and writable masks
// ************************************************************
`define CLK_RESET_VALUE 8'h00
`define CLK_MASK_SPEED_B 8'h01
`define CLK_MASK_LOOP_CTRL 8'h06
// ************************************************************
// oscillator periods per cycle, minus one
// ************************************************************
`define CLK_PER_SLOW_M1 4'hb
`define CLK_PER_DBL_M1 4'h5
`endif

// [clock_speed_pkg.sv]
package clock_speed_pkg;
    // peripheral enable index
    typedef enum logic [2:0] {
        PER_SERIAL, PER_T0, PER_T1, PER_T2, PER_SPI, PER_TWI, PER_WDOG, PER_CARRAY
    } periph_idx_t;
endpackage

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic mclk_in; // 100 mhz system clock
    logic sys_rst_in; // synchronous reset, active high
    logic [7:0] sfr_addr_in;
    logic [7:0] sfr_wdata_in;
    logic sfr_wr_in;
    logic sfr_rd_in;
    logic loop_lock_in; // lock level from the analog loop
    logic [7:0] sfr_rdata_out;
    logic loop_enable_out;
    logic [3:0] feedback_divider_out;
    logic [3:0] reference_divider_out;
    logic external_usb_clock_select_out;
    logic osc_enable_out;
    logic cpu_cycle_en_out;
    logic [7:0] periph_cycle_en_out;
    int n_mismatch = 0; // counted mismatches
    int n_compared = 0; // counted comparisons
    // first control byte that slows only peripheral k, double speed on
    logic [7:0] amap [8] = '{8'h11, 8'h03, 8'h05, 8'h09, 8'h01, 8'h81, 8'h41, 8'h21};

    clock_speed_and_usb_pll_control DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .loop_lock_in(loop_lock_in),
        .loop_enable_out(loop_enable_out), .feedback_divider_out(feedback_divider_out),
        .reference_divider_out(reference_divider_out),
        .external_usb_clock_select_out(external_usb_clock_select_out),
        .osc_enable_out(osc_enable_out), .cpu_cycle_en_out(cpu_cycle_en_out),
        .periph_cycle_en_out(periph_cycle_en_out));

    // clock generator, 10 ns period
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1 sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(posedge mclk_in);
        #1 sfr_wr_in = 1'b0;
    endtask

    // one-cycle read strobe, data registered at the next edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        #1 sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(posedge mclk_in);
        #1 sfr_rd_in = 1'b0;
        cmp("rdata", exp, sfr_rdata_out);
    endtask

    // strobe selector: 8 is the machine cycle, else a peripheral
    function automatic logic hit(input int sel);
        return (sel == 8) ? cpu_cycle_en_out : periph_cycle_en_out[sel];
    endfunction

    // cycles from one strobe to the next, bounded at 40
    task automatic period(input int sel, input logic [7:0] exp);
        int n;
        n = 0;
        // skip a strobe already showing: its reload predates the last write
        do begin
            @(posedge mclk_in);
            #1 n++;
        end while (hit(sel) !== 1'b1 && n < 40);
        n = 0;
        do begin
            @(posedge mclk_in);
            #1 n++;
        end while (hit(sel) !== 1'b1 && n < 40);
        cmp("period", exp, 8'(n));
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rd(8'h8f, 8'h00);
        rd(8'ha3, 8'h00);
        rd(8'ha4, 8'h00);
        rd(8'haf, 8'h00);
        rd(8'h90, 8'h00);
        cmp("osc", 8'h01, {7'h00, osc_enable_out});
    endtask

    // legal writes keep reserved bits clear; lock bit is not writable
    task automatic t_reserved;
        wr(8'haf, 8'h01);
        rd(8'haf, 8'h01);
        wr(8'ha3, 8'h01);
        rd(8'ha3, 8'h00);
        wr(8'haf, 8'h00);
    endtask

    task automatic t_divider;
        wr(8'ha4, 8'hb9);
        cmp("fb_div", 8'h0b, {4'h0, feedback_divider_out});
        cmp("ref_div", 8'h09, {4'h0, reference_divider_out});
        rd(8'ha4, 8'hb9);
    endtask

    // usb source steering and loop enable, both ways
    task automatic t_source;
        wr(8'ha3, 8'h06);
        cmp("src", 8'h05, {5'h00, external_usb_clock_select_out, osc_enable_out,
            loop_enable_out});
        wr(8'ha3, 8'h00);
        cmp("src", 8'h02, {5'h00, external_usb_clock_select_out, osc_enable_out,
            loop_enable_out});
    endtask

    // lock flag follows the loop, not software
    task automatic t_lock;
        wr(8'ha3, 8'h02);
        loop_lock_in = 1'b1;
        repeat (4) @(posedge mclk_in);
        rd(8'ha3, 8'h03);
        wr(8'ha3, 8'h02);
        rd(8'ha3, 8'h03);
        loop_lock_in = 1'b0;
        repeat (4) @(posedge mclk_in);
        rd(8'ha3, 8'h02);
        wr(8'ha3, 8'h00);
    endtask

    // standard mode ignores the bits, then each bit alone in double mode
    task automatic t_speed;
        wr(8'h8f, 8'hfe);
        wr(8'haf, 8'h01);
        period(8, 8'h0c);
        for (int j = 0; j < 8; j++) period(j, 8'h0c);
        wr(8'haf, 8'h00);
        wr(8'h8f, 8'h01);
        period(8, 8'h06);
        for (int k = 0; k < 8; k++) begin
            wr(8'h8f, amap[k]);
            wr(8'haf, (k == 4) ? 8'h01 : 8'h00);
            for (int j = 0; j < 8; j++) period(j, (j == k) ? 8'h0c : 8'h06);
        end
    endtask

    // ************************************************************
    // verdict, watchdog and main sequence
    // ************************************************************
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // cut a hang short well past the expected run length
    initial begin
        #200000 n_mismatch++;
        conclude();
    end

    initial begin
        sys_rst_in = 1'b1;
        sfr_addr_in = 8'h00;
        sfr_wdata_in = 8'h00;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
        loop_lock_in = 1'b0;
        repeat (3) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        t_reset();
        t_reserved();
        t_divider();
        t_source();
        t_lock();
        t_speed();
        conclude();
    end
endmodule
`default_nettype wire
